// [shared/loop_clock_pkg.sv]
// Constants for the loop clock multiplier control block.
// Assumes an 8-bit special register port on the system clock.
package loop_clock_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h89;
    localparam logic [7:0] ADDR_PREDIVIDER = 8'h8d;
    localparam logic [7:0] ADDR_MULTIPLIER = 8'h8e;
    localparam logic [7:0] ADDR_FILTER_RANGE = 8'h8f;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LOOP_CONTROL = 8'h00;
    localparam logic [7:0] RST_PREDIVIDER = 8'h01;
    localparam logic [7:0] RST_MULTIPLIER = 8'h01;
    localparam logic [7:0] RST_FILTER_RANGE = 8'h31;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_BIAS_POWER = 0;
    localparam int BIT_LOOP_ENABLE = 1;
    localparam int BIT_REF_SELECT = 2;
    localparam int BIT_RESERVED = 3;
    localparam int BIT_LOCK_FLAG = 4;
    localparam int PREDIV_WIDTH = 5;
    localparam int MULT_WIDTH = 8;
    localparam int FILTER_WIDTH = 6;
    localparam int RANGE_LSB = 4;
    // Zero field values stand for these factors
    localparam logic [5:0] PREDIV_ZERO_FACTOR = 6'h20;
    localparam logic [8:0] MULT_ZERO_FACTOR = 9'h100;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_TIME_NS = 5000;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : loop_clock_pkg

// [hdl/loop_clock_control.sv]
// Register and control logic of the loop clock multiplier.
// Assumes the analog loop sits outside and reports lock on a pin.
// Assumes a write strobe of one cycle and a read answer one clock
// after the address; no other bus reaches the registers.
module loop_clock_control (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_loop_locked,
    input wire logic [1:0] i_internal_osc_divide,
    output logic o_bias_power_enable,
    output logic o_loop_reset,
    output logic o_reference_select,
    output logic [1:0] o_internal_osc_divide,
    output logic [5:0] o_predivide_factor,
    output logic [8:0] o_multiplier_factor,
    output logic [1:0] o_oscillator_range,
    output logic [3:0] o_loop_filter_setting,
    output logic o_settle_done
);
    import loop_clock_pkg::*;

    logic bias_power_enable_reg;
    logic loop_enable_reg;
    logic reference_select_reg;
    logic [PREDIV_WIDTH-1:0] predivide_value_reg;
    logic [MULT_WIDTH-1:0] multiplier_value_reg;
    logic [FILTER_WIDTH-1:0] loop_filter_range_reg;
    logic lock_meta_reg;
    logic lock_sync_reg;
    logic lock_flag_reg;
    logic [15:0] settle_count_reg;
    logic [7:0] rdata_next;
    logic loop_running;
    logic wr_control;
    logic wr_predivider;
    logic wr_multiplier;
    logic wr_filter_range;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // One strobe per register; other addresses write nothing
    assign wr_control = i_reg_wr && (i_reg_addr == ADDR_LOOP_CONTROL);
    assign wr_predivider = i_reg_wr && (i_reg_addr == ADDR_PREDIVIDER);
    assign wr_multiplier = i_reg_wr && (i_reg_addr == ADDR_MULTIPLIER);
    assign wr_filter_range = i_reg_wr && (i_reg_addr == ADDR_FILTER_RANGE);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Bias power bit; bit 3 and bits 7-5 are not stored
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            bias_power_enable_reg <= RST_LOOP_CONTROL[BIT_BIAS_POWER];
        end else if (wr_control) begin
            bias_power_enable_reg <= i_reg_wdata[BIT_BIAS_POWER];
        end
    end

    // Loop enable bit
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            loop_enable_reg <= RST_LOOP_CONTROL[BIT_LOOP_ENABLE];
        end else if (wr_control) begin
            loop_enable_reg <= i_reg_wdata[BIT_LOOP_ENABLE];
        end
    end

    // Reference select bit
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            reference_select_reg <= RST_LOOP_CONTROL[BIT_REF_SELECT];
        end else if (wr_control) begin
            reference_select_reg <= i_reg_wdata[BIT_REF_SELECT];
        end
    end

    // ------------------------------------------------------------
    // Pre-divider, multiplier and filter registers
    // ------------------------------------------------------------
    // Pre-divide field; top three bits dropped on write
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            predivide_value_reg <= RST_PREDIVIDER[PREDIV_WIDTH-1:0];
        end else if (wr_predivider) begin
            predivide_value_reg <= i_reg_wdata[PREDIV_WIDTH-1:0];
        end
    end

    // Multiplier field takes the whole byte
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            multiplier_value_reg <= RST_MULTIPLIER;
        end else if (wr_multiplier) begin
            multiplier_value_reg <= i_reg_wdata;
        end
    end

    // Filter and range fields; top two bits dropped on write
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            loop_filter_range_reg <= RST_FILTER_RANGE[FILTER_WIDTH-1:0];
        end else if (wr_filter_range) begin
            loop_filter_range_reg <=
                i_reg_wdata[FILTER_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Lock flag
    // ------------------------------------------------------------
    // Lock pin comes from the analog loop, so synchronise it
    // First stage feeds only the second stage
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
        end else begin
            lock_meta_reg <= i_loop_locked;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    assign loop_running = bias_power_enable_reg && loop_enable_reg;

    // Flag forced low while loop is held or unpowered
    // Follows the synchronised pin only while the loop runs
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            lock_flag_reg <= 1'b0;
        end else begin
            lock_flag_reg <= loop_running && lock_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Settle counter
    // ------------------------------------------------------------
    // Counts power-on time, for software pacing of the enable
    // Holds at the end count until power is dropped
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !bias_power_enable_reg) begin
            settle_count_reg <= 16'h0000;
        end else if (settle_count_reg < 16'(SETTLE_CYCLES)) begin
            settle_count_reg <= settle_count_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unused and reserved bits read as zero
    // Reserved control bit 3 has no storage, so it always reads zero
    always_comb begin
        rdata_next = 8'h00;
        case (i_reg_addr)
            ADDR_LOOP_CONTROL: begin
                // Gated again so a write that stops the loop hides
                // the flag from the very next read
                rdata_next[BIT_LOCK_FLAG] =
                    lock_flag_reg && loop_running;
                rdata_next[BIT_REF_SELECT] = reference_select_reg;
                rdata_next[BIT_LOOP_ENABLE] = loop_enable_reg;
                rdata_next[BIT_BIAS_POWER] = bias_power_enable_reg;
            end
            ADDR_PREDIVIDER: begin
                rdata_next = {3'h0, predivide_value_reg};
            end
            ADDR_MULTIPLIER: begin
                rdata_next = multiplier_value_reg;
            end
            ADDR_FILTER_RANGE: begin
                rdata_next = {2'h0, loop_filter_range_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // Registered read data
    // Answer stands one clock after the address is presented
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Controls toward the analog loop
    // ------------------------------------------------------------
    // Bias goes straight out of the control register
    assign o_bias_power_enable = bias_power_enable_reg;
    // Loop stays in reset unless both powered and enabled
    assign o_loop_reset = !loop_running;
    // Reference picks internal (0) or external (1) oscillator
    assign o_reference_select = reference_select_reg;
    // Internal divide applies only to the internal reference
    assign o_internal_osc_divide =
        reference_select_reg ? 2'h0 : i_internal_osc_divide;

    // ------------------------------------------------------------
    // Decoded factors and filter fields
    // ------------------------------------------------------------
    // Zero fields stand for the largest factors
    assign o_predivide_factor = (predivide_value_reg == '0) ?
        PREDIV_ZERO_FACTOR : {1'h0, predivide_value_reg};
    assign o_multiplier_factor = (multiplier_value_reg == '0) ?
        MULT_ZERO_FACTOR : {1'h0, multiplier_value_reg};
    // Range and filter fields pass through unchanged
    assign o_oscillator_range =
        loop_filter_range_reg[RANGE_LSB+1:RANGE_LSB];
    assign o_loop_filter_setting = loop_filter_range_reg[3:0];
    // Status only; software still times its own wait
    assign o_settle_done = (settle_count_reg == 16'(SETTLE_CYCLES));
endmodule // loop_clock_control

// [testbench/loop_clock_props.sv]
// Port checker for the loop clock control block.
// Assumes a bind onto loop_clock_control and one clock domain.
module loop_clock_props (
    input wire logic i_clk_sys, input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr, input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata, input wire logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_internal_osc_divide,
    input wire logic o_bias_power_enable, input wire logic o_loop_reset,
    input wire logic o_reference_select, input wire logic o_settle_done,
    input wire logic [1:0] o_internal_osc_divide,
    input wire logic [5:0] o_predivide_factor,
    input wire logic [8:0] o_multiplier_factor,
    input wire logic [1:0] o_oscillator_range,
    input wire logic [3:0] o_loop_filter_setting
);
    timeunit 1ns;
    timeprecision 100ps;
    import loop_clock_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Write strobes per register
    wire wc = i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL;
    wire wp = i_reg_wr && i_reg_addr == ADDR_PREDIVIDER;
    wire wm = i_reg_wr && i_reg_addr == ADDR_MULTIPLIER;
    wire wf = i_reg_wr && i_reg_addr == ADDR_FILTER_RANGE;
    a_ctl_write: assert property (wc |=>
        o_bias_power_enable == $past(i_reg_wdata[0]) &&
        o_reference_select == $past(i_reg_wdata[2]) &&
        o_loop_reset == !($past(i_reg_wdata[0]) && $past(i_reg_wdata[1])))
        else $error("control write not applied");
    a_prediv_value: assert property (wp |=> o_predivide_factor ==
        ($past(i_reg_wdata[4:0]) == 5'h00 ? 6'h20 : $past(i_reg_wdata[4:0])))
        else $error("pre-divide factor wrong");
    a_mult_value: assert property (wm |=> o_multiplier_factor ==
        ($past(i_reg_wdata) == 8'h00 ? 9'h100 : $past(i_reg_wdata)))
        else $error("multiplier factor wrong");
    a_filter_fields: assert property (wf |=>
        {o_oscillator_range, o_loop_filter_setting} == $past(i_reg_wdata[5:0]))
        else $error("filter fields wrong");
    a_osc_pass: assert property (!o_reference_select &&
        $stable(o_reference_select) && $stable(i_internal_osc_divide)
        |-> o_internal_osc_divide == i_internal_osc_divide)
        else $error("internal divide not passed");
    a_ctl_unused: assert property (i_reg_addr == ADDR_LOOP_CONTROL
        |=> o_reg_rdata[7:5] == 3'h0 && !o_reg_rdata[3])
        else $error("control unused bits not zero");
    a_flt_unused: assert property (i_reg_addr == ADDR_FILTER_RANGE
        |=> o_reg_rdata[7:6] == 2'h0) else $error("filter top bits set");
    a_lock_clear: assert property (o_loop_reset &&
        i_reg_addr == ADDR_LOOP_CONTROL |=> !o_reg_rdata[4])
        else $error("lock flag set while loop in reset");
    a_settle_wait: assert property ($rose(o_bias_power_enable)
        |=> !o_settle_done [*8]) else $error("settle done too early");
endmodule // loop_clock_props

// [testbench/testbench.sv]
// Self-checking bench for the loop clock control block.
// Assumes loop_clock_pkg compiled first; lock pin is driven by the bench.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import loop_clock_pkg::*;
    logic clk, rst_n, we, lk, chk, be, lr, rs, sd;
    logic [7:0] a, wd, rdata, mul, d;
    logic [1:0] oi, oo, rg;
    logic [5:0] pf, flt;
    logic [8:0] mf;
    logic [3:0] fs;
    logic [2:0] ctl;
    logic [4:0] pdv;
    logic [33:0] q[$];
    logic [33:0] ev;
    int err_total, cmp_count;
    localparam logic [7:0] ADS[5] = '{8'h89, 8'h8d, 8'h8e, 8'h8f, 8'h8a};
    wire [33:0] seen = {rdata, pf, mf, rg, fs, be, lr, rs, oo};
    loop_clock_control loop_clock_control_i (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_reg_addr(a), .i_reg_wr(we), .i_reg_wdata(wd), .o_reg_rdata(rdata),
        .i_loop_locked(lk), .i_internal_osc_divide(oi),
        .o_bias_power_enable(be), .o_loop_reset(lr), .o_reference_select(rs),
        .o_internal_osc_divide(oo), .o_predivide_factor(pf),
        .o_multiplier_factor(mf), .o_oscillator_range(rg),
        .o_loop_filter_setting(fs), .o_settle_done(sd));
    // Expected outputs from the bench's register copy
    function automatic logic [33:0] expv(input logic [7:0] x);
        logic [7:0] r;
        r = x == ADDR_LOOP_CONTROL ? {3'h0, lk & ctl[0] & ctl[1], 1'b0, ctl} :
            x == ADDR_PREDIVIDER ? {3'h0, pdv} : x == ADDR_MULTIPLIER ? mul :
            x == ADDR_FILTER_RANGE ? {2'h0, flt} : 8'h00;
        return {r, pdv == 5'h00 ? 6'h20 : {1'b0, pdv},
            mul == 8'h00 ? 9'h100 : {1'b0, mul}, flt, ctl[0],
            !(ctl[0] & ctl[1]), ctl[2], ctl[2] ? 2'h0 : oi};
    endfunction
    task automatic put(input logic [7:0] x, input logic [7:0] v);
        @(posedge clk); a <= x; wd <= v; we <= 1'b1;
        @(posedge clk); we <= 1'b0;
        if (x == ADDR_LOOP_CONTROL) ctl = v[2:0];
        if (x == ADDR_PREDIVIDER) pdv = v[4:0];
        if (x == ADDR_MULTIPLIER) mul = v;
        if (x == ADDR_FILTER_RANGE) flt = v[5:0];
    endtask
    task automatic get(input logic [7:0] x);
        @(posedge clk); a <= x;
        repeat (2) @(posedge clk);
        q.push_back(expv(x)); chk <= 1'b1;
        @(posedge clk); chk <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Output watcher takes the oldest note
    always @(negedge clk) if (chk) begin
        ev = q.pop_front(); cmp_count++;
        if (seen !== ev) begin err_total++;
            $display("unexpected outputs: expected %h seen %h", ev, seen); end
    end
    initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
    initial begin #(CLK_PERIOD_NS * 8000); err_total++; final_report(); end
    // Main sequence
    initial begin
        {rst_n, we, lk, chk, a, wd, oi, ctl} = '0;
        pdv = 5'h01; mul = 8'h01; flt = 6'h31;
        void'($urandom(32'h9e773690));
        repeat (3) @(posedge clk); rst_n <= 1'b1;
        foreach (ADS[i]) get(ADS[i]);
        // Reserved control bit 3 written as zero, enable left off
        foreach (ADS[i]) begin
            put(ADS[i], ADS[i] == ADDR_LOOP_CONTROL ? 8'hf5 : 8'hff);
            get(ADS[i]);
        end
        put(8'h8d, 8'h00); put(8'h8e, 8'h00); get(8'h8d); get(8'h8e);
        for (int i = 0; i < 40; i++) begin
            d = 8'($urandom); oi <= 2'($urandom);
            // Bit 3 kept zero; enable waits for the paced sequence below
            if (i % 4 == 0) d[3:1] = {1'b0, d[2], 1'b0};
            put(ADS[i % 4], d);
            get(ADS[i % 4]);
        end
        for (int i = 0; i < 16; i++) begin
            put(8'h8f, {2'h0, 2'(i / 4), 4'((1 << (i % 4 + 1)) - 1)});
            get(8'h8f);
        end
        put(8'h89, 8'h00); put(8'h89, 8'h01); cmp_count++;
        if (sd !== 1'b0) begin err_total++;
            $display("unexpected settle: expected 0 seen %b", sd); end
        repeat (SETTLE_CYCLES + 4) @(posedge clk); cmp_count++;
        if (sd !== 1'b1) begin err_total++;
            $display("unexpected settle: expected 1 seen %b", sd); end
        lk <= 1'b1; repeat (8) @(posedge clk); get(8'h89);
        put(8'h89, 8'h03); repeat (8) @(posedge clk); get(8'h89);
        put(8'h89, 8'h01); get(8'h89);
        final_report();
    end
endmodule // testbench
bind loop_clock_control loop_clock_props loop_clock_props_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_internal_osc_divide(i_internal_osc_divide),
    .o_bias_power_enable(o_bias_power_enable), .o_loop_reset(o_loop_reset),
    .o_reference_select(o_reference_select), .o_settle_done(o_settle_done),
    .o_internal_osc_divide(o_internal_osc_divide),
    .o_predivide_factor(o_predivide_factor),
    .o_multiplier_factor(o_multiplier_factor),
    .o_oscillator_range(o_oscillator_range),
    .o_loop_filter_setting(o_loop_filter_setting));
